// file: hdl/rcw_defines.svh
`ifndef RCW_DEFINES_SVH
`define RCW_DEFINES_SVH

// register byte offsets
`define RCW_OFF_STATUS      12'h000
`define RCW_OFF_CONFIG      12'h004
`define RCW_OFF_CLKSTAT     12'h008

// reset_cause_status bit positions
`define RCW_B_IRQ_PRIORITY_ENABLE          7
`define RCW_B_SOFT_BROWNOUT_ENABLE        6
`define RCW_B_RI            4
`define RCW_B_TO            3
`define RCW_B_PD            2
`define RCW_B_POR           1
`define RCW_B_BOR           0
`define RCW_STATUS_RST      8'h5C
`define RCW_STATUS_WMASK    8'hD3

// configuration register fields
`define RCW_CFG_BOR_LSB     0
`define RCW_CFG_PIN_EN      2
`define RCW_CFG_MODE_LSB    3
`define RCW_CFG_FREQ_LSB    5
`define RCW_CFG_RST         8'h85
`define RCW_FREQ_1MHZ       3'h4

// clock status register fields
`define RCW_CS_PRI_RDY      0
`define RCW_CS_INT_STB      1
`define RCW_CS_CPU_RUN      2
`define RCW_CS_BOR_ACT      3
`define RCW_CS_CAUSE_LSB    4

// timing
`define RCW_CLK_NS          4
`define RCW_PLL_LOCK_NS     2000000
`define RCW_PLL_LOCK_CYC    (`RCW_PLL_LOCK_NS / `RCW_CLK_NS)
`define RCW_CPU_READY_CYC   8
`define RCW_OST_CYC         1024
`define RCW_STAB_CYC        64
`define RCW_FILT_CYC        16

`endif

// file: hdl/rcw_pkg.sv
package rcw_pkg;

    typedef enum logic [1:0]
    {
        RCW_SRC_PRI  = 2'h0,
        RCW_SRC_SEC  = 2'h1,
        RCW_SRC_INT  = 2'h2,
        RCW_SRC_NONE = 2'h3
    } rcw_src_e;

    typedef enum logic [1:0]
    {
        RCW_OSC_XTAL     = 2'h0,
        RCW_OSC_XTAL_PLL = 2'h1,
        RCW_OSC_EXT_RC   = 2'h2,
        RCW_OSC_INTERNAL_OSC   = 2'h3
    } rcw_osc_e;

    typedef enum logic [2:0]
    {
        RCW_CAUSE_POR       = 3'h0,
        RCW_CAUSE_PIN_RUN   = 3'h1,
        RCW_CAUSE_PIN_PM    = 3'h2,
        RCW_CAUSE_WDT       = 3'h3,
        RCW_CAUSE_BOR       = 3'h4,
        RCW_CAUSE_INSTR     = 3'h5,
        RCW_CAUSE_STK_FULL  = 3'h6,
        RCW_CAUSE_STK_UNDER = 3'h7
    } rcw_cause_e;

    typedef enum logic [2:0]
    {
        RCW_ST_RUN    = 3'b001,
        RCW_ST_LOWPWR = 3'b010,
        RCW_ST_WAKE   = 3'b100
    } rcw_state_e;

endpackage : rcw_pkg

// file: hdl/rcw_top.sv
`include "rcw_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module rcw_top
#(
    parameter logic [19:0] CPU_READY_CYC = 20'(`RCW_CPU_READY_CYC),
    parameter logic [19:0] OST_CYC       = 20'(`RCW_OST_CYC),
    parameter logic [19:0] PLL_LOCK_CYC  = 20'(`RCW_PLL_LOCK_CYC),
    parameter logic [19:0] STAB_CYC      = 20'(`RCW_STAB_CYC),
    parameter logic [19:0] FILT_CYC      = 20'(`RCW_FILT_CYC)
)
(
    // clock and reset (srst is the power-on reset)
    input  wire logic             core_clk,
    input  wire logic             srst,
    // apb slave
    input  wire logic [11:0]      paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // external reset pin, input only
    input  wire logic             ext_reset_pin_n,
    // core events, one-cycle pulses
    input  wire logic             bor_event,
    input  wire logic             wdt_timeout,
    input  wire logic             reset_instr,
    input  wire logic             stack_full,
    input  wire logic             stack_underflow,
    input  wire logic             watchdog_clear_instr,
    input  wire logic             sleep_instr,
    input  wire logic             wake_event,
    // low-power mode select, sampled with sleep_instr
    input  wire logic             idle_en,
    input  wire rcw_pkg::rcw_src_e idle_src,
    // status towards the core
    output logic                  core_reset_req,
    output logic                  cpu_run,
    output logic                  primary_clock_ready_flag,
    output logic                  internal_clock_stable_flag,
    output logic                  bor_active,
    output logic                  irq_priority_enable,
    output logic                  ext_pin_digital,
    output logic      [2:0]       int_osc_freq_sel
);
    import rcw_pkg::*;

    typedef struct packed
    {
        rcw_state_e  fsm;
        rcw_src_e    src;
        logic        pin_s1;
        logic        pin_s2;
        logic [19:0] filt_cnt;
        logic        pin_low;
        logic [7:0]  status;
        logic [7:0]  cfg;
        rcw_cause_e  cause;
        logic [19:0] cpu_cnt;
        logic [19:0] osc_cnt;
        logic        osc_busy;
        logic [19:0] stab_cnt;
        logic        stab_busy;
        logic        pri_rdy;
        logic        int_stb;
        logic        run;
        logic        rst_req;
        logic        bor_act;
        logic        ext_dig;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } rcw_state_s;

    rcw_state_s s_r;
    rcw_state_s s_nxt;

    function automatic logic [19:0] rcw_dec(input logic [19:0] v);
        rcw_dec = (v == 20'h0) ? 20'h0 : v - 20'h1;
    endfunction : rcw_dec

    // start-up timer only for crystal targets, never from primary idle
    function automatic logic rcw_need_ost(input rcw_src_e src, input rcw_osc_e mode);
        rcw_need_ost = (src != RCW_SRC_PRI) &&
                       ((mode == RCW_OSC_XTAL) || (mode == RCW_OSC_XTAL_PLL));
    endfunction : rcw_need_ost

    function automatic logic [19:0] rcw_osc_load(input rcw_osc_e mode);
        if (mode == RCW_OSC_XTAL_PLL)
        begin
            rcw_osc_load = OST_CYC + PLL_LOCK_CYC - 20'h1;
        end
        else
        begin
            rcw_osc_load = OST_CYC - 20'h1;
        end
    endfunction : rcw_osc_load

    // brown-out enable by configuration field, sleep and soft bit
    function automatic logic rcw_bor_on(input logic [1:0] fld, input logic sb,
                                        input logic asleep);
        case (fld)
            2'h1:    rcw_bor_on = sb;
            2'h2:    rcw_bor_on = !asleep;
            2'h3:    rcw_bor_on = 1'b1;
            default: rcw_bor_on = 1'b0;
        endcase
    endfunction : rcw_bor_on

    logic [1:0] bor_fld;
    rcw_osc_e   osc_mode;
    logic       pin_en;
    logic [7:0] status_rd;
    logic       wr_acc;
    logic       pin_rst;
    logic       any_rst;

    always_comb
    begin
        bor_fld  = s_r.cfg[`RCW_CFG_BOR_LSB +: 2];
        osc_mode = rcw_osc_e'(s_r.cfg[`RCW_CFG_MODE_LSB +: 2]);
        pin_en   = s_r.cfg[`RCW_CFG_PIN_EN];
        // soft enable reads zero unless software control is chosen
        status_rd = s_r.status;
        status_rd[`RCW_B_SOFT_BROWNOUT_ENABLE] = s_r.status[`RCW_B_SOFT_BROWNOUT_ENABLE] && (bor_fld == 2'h1);
        status_rd[5] = 1'b0;
        wr_acc  = psel && penable && pwrite && s_r.pready;
        pin_rst = pin_en && s_r.pin_low;
        any_rst = pin_rst || bor_event || reset_instr || stack_full ||
                  stack_underflow || (wdt_timeout && (s_r.fsm == RCW_ST_RUN));
    end

    always_comb
    begin
        s_nxt = s_r;

        // pin: two flops, then a low-level glitch filter
        s_nxt.pin_s1  = ext_reset_pin_n;
        s_nxt.pin_s2  = s_r.pin_s1;
        s_nxt.ext_dig = s_r.pin_s2;
        if (s_r.pin_s2)
        begin
            s_nxt.filt_cnt = 20'h0;
            s_nxt.pin_low  = 1'b0;
        end
        else if (s_r.filt_cnt >= FILT_CYC - 20'h1)
        begin
            s_nxt.pin_low = 1'b1;
        end
        else
        begin
            s_nxt.filt_cnt = s_r.filt_cnt + 20'h1;
        end

        // apb: answer in the first access cycle
        s_nxt.pready  = psel && !penable;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata  = 32'h0;
        if (psel && !penable)
        begin
            if (paddr == `RCW_OFF_STATUS)
            begin
                s_nxt.prdata = {24'h0, status_rd};
            end
            else if (paddr == `RCW_OFF_CONFIG)
            begin
                s_nxt.prdata = {24'h0, s_r.cfg};
            end
            else if (paddr == `RCW_OFF_CLKSTAT)
            begin
                s_nxt.prdata[`RCW_CS_PRI_RDY]      = s_r.pri_rdy;
                s_nxt.prdata[`RCW_CS_INT_STB]      = s_r.int_stb;
                s_nxt.prdata[`RCW_CS_CPU_RUN]      = s_r.run;
                s_nxt.prdata[`RCW_CS_BOR_ACT]      = s_r.bor_act;
                s_nxt.prdata[`RCW_CS_CAUSE_LSB+:3] = s_r.cause;
            end
            else
            begin
                s_nxt.pslverr = 1'b1;
            end
        end

        // software writes first, so a same-cycle hardware event wins
        if (wr_acc && (paddr == `RCW_OFF_STATUS))
        begin
            s_nxt.status = (s_r.status & ~8'(`RCW_STATUS_WMASK)) |
                           (pwdata[7:0] & 8'(`RCW_STATUS_WMASK));
        end
        else if (wr_acc && (paddr == `RCW_OFF_CONFIG))
        begin
            s_nxt.cfg = pwdata[7:0];
        end

        // reset causes; only the core is reset, the pin is never driven
        s_nxt.rst_req = any_rst;
        if (pin_rst)
        begin
            s_nxt.cause = (s_r.fsm == RCW_ST_RUN) ? RCW_CAUSE_PIN_RUN
                                                  : RCW_CAUSE_PIN_PM;
        end
        else if (bor_event)
        begin
            s_nxt.cause = RCW_CAUSE_BOR;
            s_nxt.status[`RCW_B_BOR] = 1'b0;
        end
        else if (wdt_timeout && (s_r.fsm == RCW_ST_RUN))
        begin
            s_nxt.cause = RCW_CAUSE_WDT;
        end
        else if (reset_instr)
        begin
            s_nxt.cause = RCW_CAUSE_INSTR;
            s_nxt.status[`RCW_B_RI] = 1'b0;
        end
        else if (stack_full)
        begin
            s_nxt.cause = RCW_CAUSE_STK_FULL;
        end
        else if (stack_underflow)
        begin
            s_nxt.cause = RCW_CAUSE_STK_UNDER;
        end

        if (watchdog_clear_instr)
        begin
            s_nxt.status[`RCW_B_TO] = 1'b1;
            s_nxt.status[`RCW_B_PD] = 1'b1;
        end
        if (wdt_timeout)
        begin
            s_nxt.status[`RCW_B_TO] = 1'b0;
        end

        // stabilization runs on regardless of execution
        if (s_r.stab_busy)
        begin
            s_nxt.stab_cnt = rcw_dec(s_r.stab_cnt);
            if (s_r.stab_cnt == 20'h0)
            begin
                s_nxt.stab_busy = 1'b0;
                s_nxt.int_stb   = 1'b1;
            end
        end

        case (s_r.fsm)
            RCW_ST_RUN:
            begin
                if (sleep_instr && !any_rst)
                begin
                    s_nxt.fsm = RCW_ST_LOWPWR;
                    s_nxt.run = 1'b0;
                    s_nxt.src = idle_en ? idle_src : RCW_SRC_NONE;
                    s_nxt.status[`RCW_B_TO] = !wdt_timeout;
                    s_nxt.status[`RCW_B_PD] = 1'b0;
                    if (idle_en && (idle_src == RCW_SRC_PRI))
                    begin
                        s_nxt.pri_rdy = s_r.pri_rdy;
                    end
                    else
                    begin
                        // primary oscillator is shut down here
                        s_nxt.pri_rdy = 1'b0;
                    end
                end
            end
            RCW_ST_LOWPWR:
            begin
                if (wake_event || wdt_timeout || any_rst)
                begin
                    s_nxt.fsm     = RCW_ST_WAKE;
                    s_nxt.cpu_cnt = CPU_READY_CYC - 20'h1;
                    // both delays start together
                    s_nxt.osc_busy = rcw_need_ost(s_r.src, osc_mode);
                    s_nxt.osc_cnt  = rcw_osc_load(osc_mode);
                    if ((osc_mode == RCW_OSC_INTERNAL_OSC) && (s_r.src != RCW_SRC_INT) &&
                        (s_r.src != RCW_SRC_PRI))
                    begin
                        s_nxt.int_stb   = 1'b0;
                        s_nxt.stab_busy = 1'b1;
                        s_nxt.stab_cnt  = STAB_CYC - 20'h1;
                    end
                end
            end
            RCW_ST_WAKE:
            begin
                s_nxt.cpu_cnt = rcw_dec(s_r.cpu_cnt);
                if (s_r.osc_busy)
                begin
                    s_nxt.osc_cnt = rcw_dec(s_r.osc_cnt);
                    if (s_r.osc_cnt == 20'h0)
                    begin
                        s_nxt.osc_busy = 1'b0;
                        s_nxt.pri_rdy  = 1'b1;
                    end
                end
                // execution starts on the cycle after both delays end
                // an expiring start-up count ends its delay on this same edge
                if ((s_r.cpu_cnt == 20'h0) && (!s_r.osc_busy || (s_r.osc_cnt == 20'h0)))
                begin
                    s_nxt.fsm = RCW_ST_RUN;
                    s_nxt.run = 1'b1;
                    if ((osc_mode != RCW_OSC_INTERNAL_OSC) && !s_r.pri_rdy)
                    begin
                        s_nxt.pri_rdy = 1'b1;
                    end
                end
            end
            default:
            begin
                s_nxt.fsm = RCW_ST_RUN;
            end
        endcase

        s_nxt.bor_act = rcw_bor_on(bor_fld, s_r.status[`RCW_B_SOFT_BROWNOUT_ENABLE],
                                   (s_r.fsm != RCW_ST_RUN) && (s_r.src == RCW_SRC_NONE));
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            // power-on: begin as a wake from sleep with full start-up
            s_r           <= '0;
            s_r.fsm       <= RCW_ST_WAKE;
            s_r.src       <= RCW_SRC_NONE;
            s_r.pin_s1    <= 1'b1;
            s_r.pin_s2    <= 1'b1;
            s_r.ext_dig   <= 1'b1;
            s_r.status    <= 8'(`RCW_STATUS_RST);
            s_r.cfg       <= 8'(`RCW_CFG_RST);
            s_r.cause     <= RCW_CAUSE_POR;
            s_r.cpu_cnt   <= CPU_READY_CYC - 20'h1;
            s_r.osc_busy  <= 1'b1;
            s_r.osc_cnt   <= OST_CYC - 20'h1;
            s_r.bor_act   <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign prdata                     = s_r.prdata;
    assign pready                     = s_r.pready;
    assign pslverr                    = s_r.pslverr;
    assign core_reset_req             = s_r.rst_req;
    assign cpu_run                    = s_r.run;
    assign primary_clock_ready_flag   = s_r.pri_rdy;
    assign internal_clock_stable_flag = s_r.int_stb;
    assign bor_active                 = s_r.bor_act;
    assign irq_priority_enable        = s_r.status[`RCW_B_IRQ_PRIORITY_ENABLE];
    assign ext_pin_digital            = s_r.ext_dig;
    assign int_osc_freq_sel           = s_r.cfg[`RCW_CFG_FREQ_LSB +: 3];

endmodule : rcw_top

`default_nettype wire

// file: test/rcw_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rcw_monitor
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        srst,
    // apb
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pin, events and status
    input wire logic        ext_reset_pin_n,
    input wire logic        reset_instr,
    input wire logic        wdt_timeout,
    input wire logic        bor_event,
    input wire logic        stack_full,
    input wire logic        stack_underflow,
    input wire logic        sleep_instr,
    input wire logic        cpu_run,
    input wire logic        core_reset_req,
    input wire logic        ext_pin_digital,
    input wire logic [2:0]  int_osc_freq_sel
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    logic any_rst;
    assign any_rst = reset_instr | wdt_timeout | bor_event | stack_full | stack_underflow;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_sleep_req;
        sleep_instr && cpu_run && !any_rst && !core_reset_req;
    endsequence
    a_apb_no_wait: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_pready_single: assert property (pready |=> !pready)
        else $error("ready held past access");
    a_unmapped_err: assert property (s_setup ##0 (paddr > 12'h008 || paddr[1:0] != 2'h0)
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_status_bit5: assert property (s_setup ##0 (!pwrite && paddr == 12'h000)
        |=> !prdata[5] && prdata[31:8] == 24'h0)
        else $error("status unused bits not zero");
    a_reset_defaults: assert property ($fell(srst) |-> int_osc_freq_sel == 3'h4 && !cpu_run)
        else $error("wrong state after reset");
    a_instr_req: assert property (reset_instr && cpu_run |=> core_reset_req)
        else $error("reset instruction ignored");
    a_wdt_run_req: assert property (wdt_timeout && cpu_run && !sleep_instr |=> core_reset_req)
        else $error("watchdog expiry ignored");
    a_sleep_halt: assert property (s_sleep_req |=> !cpu_run)
        else $error("sleep did not halt");
    a_cpu_ready_min: assert property ($rose(cpu_run) |-> !$past(cpu_run, 8))
        else $error("execution resumed too early");
    a_pin_digital: assert property ($fell(ext_reset_pin_n) |-> ##[1:4] !ext_pin_digital)
        else $error("pin level not passed on");
endmodule : rcw_monitor
bind rcw_top rcw_monitor u_mon (.core_clk, .srst, .paddr, .psel, .penable, .pwrite, .prdata,
    .pready, .pslverr, .ext_reset_pin_n, .reset_instr, .wdt_timeout, .bor_event, .stack_full,
    .stack_underflow, .sleep_instr, .cpu_run, .core_reset_req, .ext_pin_digital,
    .int_osc_freq_sel);
`default_nettype wire

// file: test/rcw_pin_drv.sv
`timescale 1ns/1ps
`default_nettype none
module rcw_pin_drv
(
    // clock
    input wire logic       core_clk,
    // hold request
    input wire logic       go,
    input wire logic [7:0] len,
    // pin towards the device
    output logic           ext_reset_pin_n
);
    logic [7:0] cnt_r = 8'h0;
    always @(posedge core_clk)
        if (go)
            cnt_r <= len;
        else if (cnt_r != 8'h0)
            cnt_r <= cnt_r - 8'h1;
    // pulled up while not held; the device never pulls it
    assign ext_reset_pin_n = (cnt_r == 8'h0);
endmodule : rcw_pin_drv
`default_nettype wire

// file: test/reset_cause_and_wake_delay_bench.sv
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_wake_delay_bench;
    import rcw_pkg::*;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d, e, m; logic er;} rcw_row_s;
    logic        core_clk = 1'b0;
    logic        srst     = 1'b1;
    logic [11:0] paddr    = 12'h0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [31:0] pwdata   = 32'h0;
    logic [7:0]  ev       = 8'h0;
    logic        idle_en  = 1'b0;
    rcw_src_e    idle_src = RCW_SRC_PRI;
    logic        pin_go   = 1'b0;
    logic [7:0]  pin_len  = 8'h0;
    wire         pin_n;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, req, run, pri_rdy, int_stb, bor_act, irq_pe, pin_dig;
    logic [2:0]  freq;
    int          fails = 0, cmp_count = 0, cyc = 0, req_cnt = 0, n;
    rcw_row_s rows[9] = '{
        '{1'b0, 12'h000, 32'h0, 32'h5C, 32'hFF, 1'b0},
        '{1'b0, 12'h004, 32'h0, 32'h85, 32'hFF, 1'b0},
        '{1'b0, 12'h008, 32'h0, 32'h0D, 32'h7D, 1'b0},
        '{1'b0, 12'h00C, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1},
        '{1'b1, 12'h00C, 32'hFF, 32'h0, 32'h0, 1'b1},
        '{1'b1, 12'h000, 32'hFF, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h000, 32'h0, 32'hDF, 32'hFFFFFFFF, 1'b0},
        '{1'b1, 12'h000, 32'h0, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h000, 32'h0, 32'h0C, 32'hFF, 1'b0}};
    logic [2:0]  ev_cause[6] = '{3'h5, 3'h3, 3'h4, 3'h6, 3'h7, 3'h7};
    logic [4:0]  ev_flags[6] = '{5'h0F, 5'h07, 5'h06, 5'h06, 5'h06, 5'h0E};
    logic [7:0]  w_cfg[5]    = '{8'h96, 8'h8E, 8'h8E, 8'h9E, 8'h8E};
    logic        w_idle[5]   = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    rcw_src_e    w_src[5]    = '{RCW_SRC_PRI, RCW_SRC_PRI, RCW_SRC_PRI, RCW_SRC_PRI, RCW_SRC_SEC};
    int          w_exp[5]    = '{8, 24, 8, 8, 24};

    rcw_top #(.CPU_READY_CYC(20'h8), .OST_CYC(20'h8), .PLL_LOCK_CYC(20'h10),
        .STAB_CYC(20'h8), .FILT_CYC(20'h4)) u_dut (.core_clk(core_clk), .srst(srst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_reset_pin_n(pin_n),
        .reset_instr(ev[0]), .wdt_timeout(ev[1]), .bor_event(ev[2]), .stack_full(ev[3]),
        .stack_underflow(ev[4]), .watchdog_clear_instr(ev[5]), .sleep_instr(ev[6]),
        .wake_event(ev[7]), .idle_en(idle_en), .idle_src(idle_src), .core_reset_req(req),
        .cpu_run(run), .primary_clock_ready_flag(pri_rdy), .internal_clock_stable_flag(int_stb),
        .bor_active(bor_act), .irq_priority_enable(irq_pe), .ext_pin_digital(pin_dig),
        .int_osc_freq_sel(freq));
    rcw_pin_drv u_pin (.core_clk(core_clk), .go(pin_go), .len(pin_len), .ext_reset_pin_n(pin_n));

    initial
    begin
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (req === 1'b1)
            req_cnt <= req_cnt + 1;
        if (cyc == 20000)
        begin
            fails = fails + 1;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("[FAIL] %0t %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pulse(input int b);
        @(posedge core_clk);
        ev[b] <= 1'b1;
        @(posedge core_clk);
        ev <= 8'h0;
    endtask : pulse

    task automatic pin(input logic [7:0] len);
        @(posedge core_clk);
        pin_len <= len;
        pin_go  <= 1'b1;
        @(posedge core_clk);
        pin_go  <= 1'b0;
    endtask : pin

    task automatic end_of_test();
        $display("mismatches %0d, comparisons %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        repeat (30) @(posedge core_clk);
        for (int i = 0; i < 9; i++)
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk(rd & rows[i].m, rows[i].e, "register value");
            chk(err, rows[i].er, "error response");
        end
        apb(1'b1, 12'h000, 32'hFF);
        // the write lands on the edge the task returns at
        @(posedge core_clk);
        chk(irq_pe, 1'b1, "priority enable");
        for (int i = 0; i < 6; i++)
        begin
            pulse(i);
            repeat (40) @(posedge core_clk);
            apb(1'b0, 12'h000, 32'h0);
            chk(rd[4:0], ev_flags[i], "event flags");
            apb(1'b0, 12'h008, 32'h0);
            chk(rd[6:4], ev_cause[i], "reset cause");
        end
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, 12'h004, 32'(w_cfg[i]));
            idle_en <= w_idle[i];
            idle_src <= w_src[i];
            pulse(6);
            repeat (2) @(posedge core_clk);
            #1 chk(bor_act, w_idle[i], "brownout in low power");
            pulse(7);
            n = 0;
            while (run !== 1'b1 && n < 100)
            begin
                @(posedge core_clk);
                #1 n = n + 1;
            end
            chk(n, w_exp[i], "wake delay");
            repeat (12) @(posedge core_clk);
            #1 if (w_cfg[i] == 8'h8E)
                chk(pri_rdy, 1'b1, "primary ready");
            if (w_cfg[i] == 8'h9E)
                chk(int_stb, 1'b1, "internal stable");
        end
        apb(1'b0, 12'h000, 32'h0);
        chk(rd[6], 1'b0, "soft enable inert");
        apb(1'b1, 12'h004, 32'h86);
        n = req_cnt;
        pin(8'h2);
        repeat (20) @(posedge core_clk);
        chk(req_cnt, n, "short pulse");
        apb(1'b1, 12'h004, 32'h82);
        pin(8'hC);
        repeat (6) @(posedge core_clk);
        #1 chk(pin_dig, 1'b0, "digital input");
        repeat (20) @(posedge core_clk);
        chk(req_cnt, n, "disabled pin");
        apb(1'b1, 12'h004, 32'h86);
        pin(8'hC);
        repeat (30) @(posedge core_clk);
        chk(req_cnt != n, 1'b1, "pin reset");
        apb(1'b0, 12'h008, 32'h0);
        chk(rd[6:4], 3'h1, "pin cause");
        // pin reset while in a low-power mode, released before execution resumes
        pulse(6);
        pin(8'h8);
        repeat (30) @(posedge core_clk);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd[6:4], 3'h2, "pin cause in low power");
        end_of_test();
    end
endmodule : reset_cause_and_wake_delay_bench
`default_nettype wire
